// *** dv/irs_master.sv ***
// Behavioural two-wire bus master
`timescale 1ns/1ps
module irs_master (
	// Clock and spike enable
	input  wire logic clk_i,
	input  wire logic spk_i,
	// Bus, high means released
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	localparam int Q = 4;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Caller repeats the same address after a repeated start
	task automatic start();
		w(Q);
		sda_o = 1'b1;
		w(Q);
		scl_o = 1'b1;
		w(Q);
		sda_o = 1'b0;
		w(Q);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		w(Q);
		sda_o = 1'b0;
		w(Q);
		scl_o = 1'b1;
		w(Q);
		sda_o = 1'b1;
		w(Q);
	endtask
	// Two 40 ns spikes per high phase, each shorter than the 50 ns the filter is rated for
	task automatic bit_x(input logic b, output logic r);
		w(Q);
		sda_o = b;
		w(Q);
		scl_o = 1'b1;
		// Each spike straddles one sampling edge, so the filter really sees one bad sample
		if (spk_i) begin
			#59 scl_o = 1'b0;
			#40 scl_o = 1'b1;
			#120 sda_o = ~b;
			#40 sda_o = b;
		end
		w(Q);
		r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
		output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(ab, r);
		ak = ~r;
	endtask
endmodule

// *** dv/irs_slave_asserts.sv ***
// Port checks for the two-wire register slave
`timescale 1ns/1ps
module irs_slave_asserts (
	// System domain
	input wire logic       clk_sys_i,
	input wire logic       reset_i,
	// Link domain and bus pins
	input wire logic       clk_link_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	// Address select straps
	input wire logic       addr_select_high_i,
	input wire logic       addr_select_low_i,
	// Register strobes
	input wire logic       reg_wr_o,
	input wire logic       reg_rd_o,
	input wire logic [6:0] reg_addr_o,
	input wire logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	import irs_pkg::*;
	// A bus byte lasts many link cycles, so two strobes never sit close
	sequence s_quiet;
		(!reg_wr_o && !reg_rd_o) [*8];
	endsequence
	sequence s_held;
		sda_oe_o [*8];
	endsequence
	AST_WR_DEFINED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		reg_wr_o |-> reg_addr_o >= REG_WR_FIRST && reg_addr_o <= REG_WR_LAST)
		else $error("write strobe at undefined index");
	AST_STROBE_GAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(reg_wr_o || reg_rd_o) |=> s_quiet)
		else $error("strobes too close");
	AST_STROBE_EXCL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		reg_wr_o |-> !reg_rd_o)
		else $error("read and write strobe together");
	AST_ADDR_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(!reg_wr_o && !reg_rd_o) |-> $stable(reg_addr_o))
		else $error("index moved without strobe");
	AST_WDATA_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!reg_wr_o |-> $stable(reg_wdata_o))
		else $error("write data moved without strobe");
	AST_SDA_EDGE: assert property (@(posedge clk_link_i) disable iff (reset_i)
		$changed(sda_oe_o) |-> !scl_i)
		else $error("data line changed with clock high");
	AST_SDA_LOW: assert property (@(posedge clk_link_i) disable iff (reset_i)
		sda_oe_o |-> !sda_o)
		else $error("driven data line not low");
	AST_BIT_HELD: assert property (@(posedge clk_link_i) disable iff (reset_i)
		$rose(sda_oe_o) |-> s_held)
		else $error("driven bit too short");
endmodule

// *** dv/irs_slave_test.sv ***
// Bench for the two-wire register slave
`timescale 1ns/1ps
module irs_slave_test;
	import irs_pkg::*;
	logic       clk_sys, clk_link, reset, scl, m_sda, spk, s_sda, sda_oe;
	logic       reg_wr, reg_rd;
	logic [1:0] sel;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [7:0] mem [128];
	wire        sda_w;
	int         err_count, check_count;
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#17;
		forever #40 clk_link = ~clk_link;
	end
	// Pulled-up data line shared by master and slave
	assign sda_w = m_sda & (sda_oe ? s_sda : 1'b1);
	assign reg_rdata = mem[reg_addr];
	always @(posedge clk_sys) begin
		if (reg_wr === 1'b1) begin
			mem[reg_addr] <= reg_wdata;
		end
	end
	irs_slave #(.FILT_LEN(2)) dut (
		.clk_sys_i(clk_sys), .reset_i(reset), .clk_link_i(clk_link), .scl_i(scl),
		.sda_i(sda_w), .sda_o(s_sda), .sda_oe_o(sda_oe),
		.addr_select_high_i(sel[1]), .addr_select_low_i(sel[0]),
		.reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata)
	);
	irs_master m (.clk_i(clk_link), .spk_i(spk), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
	function automatic logic [7:0] iv(input int i);
		return 8'(i) ^ 8'h3c;
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [7:0] d, input logic ak);
		logic [7:0] q;
		logic       a;
		m.xfer(d, 1'b1, q, a);
		chk({7'h00, a}, {7'h00, ak});
	endtask
	task automatic rb(input logic [7:0] e, input logic last);
		logic [7:0] q;
		logic       a;
		m.xfer(8'hff, last, q, a);
		chk(q, e);
	endtask
	// Held over link edges: the link side leaves reset through two flops
	task automatic do_reset();
		@(posedge clk_sys);
		#1 reset = 1'b1;
		repeat (10) @(posedge clk_link);
		@(posedge clk_sys);
		#1 reset = 1'b0;
		repeat (6) @(posedge clk_link);
	endtask
	task automatic t_write();
		m.start();
		wb({DEV_ADDR_FIXED, sel, 1'b0}, 1'b1);
		wb(8'h13, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wb(8'h40 + 8'(i), 1'b1);
		end
		wb(8'h77, 1'b0);
		m.stop();
		for (int i = 0; i < 3; i++) begin
			chk(mem[19 + i], 8'h40 + 8'(i));
		end
		chk(mem[22], iv(22));
	endtask
	task automatic t_rd_after_wr();
		m.start();
		wb({DEV_ADDR_FIXED, sel, 1'b1}, 1'b1);
		rb(8'h42, 1'b0);
		rb(iv(22), 1'b1);
		m.stop();
	endtask
	task automatic t_read(input logic [7:0] ix, input int n);
		m.start();
		wb({DEV_ADDR_FIXED, sel, 1'b0}, 1'b1);
		wb(ix, 1'b1);
		m.start();
		wb({DEV_ADDR_FIXED, sel, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) begin
			rb(iv((ix + i) % 128), i == n - 1);
		end
		m.stop();
	endtask
	task automatic t_addr();
		m.start();
		wb({DEV_ADDR_FIXED ^ 5'h10, sel, 1'b0}, 1'b0);
		m.stop();
		@(posedge clk_sys);
		#1 sel = 2'b01;
		m.start();
		wb({DEV_ADDR_FIXED, 2'b10, 1'b0}, 1'b0);
		m.stop();
		m.start();
		wb({DEV_ADDR_FIXED, sel, 1'b0}, 1'b1);
		wb(8'h10, 1'b1);
		wb(8'h5a, 1'b1);
		m.stop();
		chk(mem[16], 8'h5a);
	endtask
	task automatic t_spike();
		spk = 1'b1;
		m.start();
		wb({DEV_ADDR_FIXED, sel, 1'b0}, 1'b1);
		wb(8'h12, 1'b1);
		wb(8'hc3, 1'b1);
		m.stop();
		spk = 1'b0;
		chk(mem[18], 8'hc3);
	endtask
	task automatic t_reset();
		do_reset();
		m.start();
		wb({DEV_ADDR_FIXED, sel, 1'b1}, 1'b1);
		rb(iv(0), 1'b0);
		rb(iv(1), 1'b1);
		m.stop();
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		spk = 1'b0;
		sel = 2'b10;
		err_count = 0;
		check_count = 0;
		for (int i = 0; i < 128; i++) begin
			mem[i] = iv(i);
		end
		do_reset();
		t_write();
		t_rd_after_wr();
		t_read(8'h1e, 3);
		t_read(8'h7f, 2);
		t_addr();
		t_spike();
		t_reset();
		conclude();
	end
endmodule
bind irs_slave irs_slave_asserts u_chk (
	.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_link_i(clk_link_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.addr_select_high_i(addr_select_high_i), .addr_select_low_i(addr_select_low_i),
	.reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o),
	.reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i)
);

// *** hdl/irs_line_filter.sv ***
// Synchroniser and spike filter for one bus line
`timescale 1ns/1ps
module irs_line_filter #(
	parameter int LEN = 2
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Line
	input  wire logic pin_i,
	output logic      level_o
);

	logic           meta;
	logic           sync;
	logic [LEN-1:0] hist;

	// Idle bus is high, so reset to high to avoid a false start
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= 1'b1;
			sync <= 1'b1;
		end else begin
			meta <= pin_i;
			sync <= meta;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hist <= '1;
		end else begin
			hist <= {hist[LEN-2:0], sync};
		end
	end

	// A level must hold for LEN samples; shorter pulses never reach the output.
	// Limitation: a spike aligned with a real edge delays that edge by up to LEN samples.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_o <= 1'b1;
		end else if (&hist) begin
			level_o <= 1'b1;
		end else if (~|hist) begin
			level_o <= 1'b0;
		end
	end

endmodule

// *** hdl/irs_slave.sv ***
// Two-wire slave port: framing on the link clock, register strobes on the system clock
`timescale 1ns/1ps
// Summary of operation
// - Multi-byte write stores first byte at addressed register, following bytes onward.
// - Every accepted write data byte advances the register index by one.
// - Advancing index 0x7F gives 0x00.
// - Bytes aimed at undefined registers are not acknowledged.
// - Register address byte is held in the index for later reads.
// - Reads return the indexed register and advance the index per byte.
// - First read right after a write returns the register just written.
// - Indices 0x10 to 0x1F always return a data byte on read.
// - Bus lines are sampled and filtered on the sampling clock.
// - Pulses up to 50 ns on the bus lines are rejected.
// - Slow sampling clock with short high plus hold can read a bit low.
// - Slow sampling clock with short start hold can miss a start.
// - Fast sampling clock with wide spikes can fake a start or stop.
// - Address is five fixed bits plus the two select pins.
// - Device is only a slave receiver or transmitter.
module irs_slave #(
	parameter int FILT_LEN = irs_pkg::FILT_LEN_DFLT
) (
	// System domain
	input  wire logic                         clk_sys_i,
	input  wire logic                         reset_i,
	// Link domain and bus pins
	input  wire logic                         clk_link_i,
	input  wire logic                         scl_i,
	input  wire logic                         sda_i,
	output logic                              sda_o,
	output logic                              sda_oe_o,
	// Address select straps
	input  wire logic                         addr_select_high_i,
	input  wire logic                         addr_select_low_i,
	// Register strobes, system domain
	output logic                              reg_wr_o,
	output logic                              reg_rd_o,
	output logic [irs_pkg::IDX_W-1:0]         reg_addr_o,
	output logic [irs_pkg::DATA_W-1:0]        reg_wdata_o,
	input  wire logic [irs_pkg::DATA_W-1:0]   reg_rdata_i
);
	import irs_pkg::*;

	// Link reset, released on the link clock
	logic                  rst_link_meta;
	logic                  rst_link;
	// Filtered lines and their previous values, synchronised select straps
	logic                  scl_f;
	logic                  sda_f;
	logic                  scl_q;
	logic                  sda_q;
	logic [1:0]            sel_meta;
	logic [1:0]            sel;
	// Framing
	irs_state_t            state;
	logic [BIT_CNT_W-1:0]  cnt;
	logic [DATA_W-1:0]     sr;
	logic                  rw;
	logic                  mnack;
	// Index
	logic [IDX_W-1:0]      idx;
	logic                  last_wr;
	// Crossing, link side
	logic                  req_tgl;
	logic                  req_we;
	logic [IDX_W-1:0]      req_addr;
	logic [DATA_W-1:0]     req_wdata;
	logic                  ack_meta;
	logic                  ack_sync;
	logic                  ack_q;
	logic [DATA_W-1:0]     rbuf;
	// Crossing, system side
	logic                  req_meta;
	logic                  req_sync;
	logic                  req_q;
	logic                  ack_tgl;
	logic [DATA_W-1:0]     rdata_x;
	// Events and the read target index
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start;
	logic                  stop;
	logic                  byte_full;
	logic                  addr_done;
	logic                  addr_hit;
	logic                  rd_begin;
	logic                  reg_done;
	logic                  wr_done;
	logic                  wr_ok;
	logic                  mack_rise;
	logic                  rd_load;
	logic                  rd_shift;
	logic                  ack_pulse;
	logic                  req_pulse;
	logic [IDX_W-1:0]      rd_tgt;

	always_ff @(posedge clk_link_i or posedge reset_i) begin
		if (reset_i) begin
			rst_link_meta <= 1'b1;
			rst_link      <= 1'b1;
		end else begin
			rst_link_meta <= 1'b0;
			rst_link      <= rst_link_meta;
		end
	end

	irs_line_filter #(
		.LEN(FILT_LEN)
	) u_scl_filter (
		.clk_i  (clk_link_i),
		.rst_i  (rst_link),
		.pin_i  (scl_i),
		.level_o(scl_f)
	);

	irs_line_filter #(
		.LEN(FILT_LEN)
	) u_sda_filter (
		.clk_i  (clk_link_i),
		.rst_i  (rst_link),
		.pin_i  (sda_i),
		.level_o(sda_f)
	);

	always_ff @(posedge clk_link_i or posedge rst_link) begin
		if (rst_link) begin
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			sel_meta <= 2'h0;
			sel      <= 2'h0;
		end else begin
			scl_q    <= scl_f;
			sda_q    <= sda_f;
			sel_meta <= {addr_select_high_i, addr_select_low_i};
			sel      <= sel_meta;
		end
	end

	// Edge and condition decode on the filtered lines
	assign scl_rise  = scl_f & ~scl_q;
	assign scl_fall  = ~scl_f & scl_q;
	assign start     = scl_f & scl_q & sda_q & ~sda_f;
	assign stop      = scl_f & scl_q & ~sda_q & sda_f;
	assign byte_full = (cnt == BITS_PER_BYTE);
	assign addr_done = scl_fall & (state == ST_ADDR) & byte_full;
	assign addr_hit  = addr_done & (sr[7:1] == {DEV_ADDR_FIXED, sel});
	assign rd_begin  = addr_hit & sr[0];
	assign reg_done  = scl_fall & (state == ST_REG) & byte_full;
	assign wr_done   = scl_fall & (state == ST_WDATA) & byte_full;
	assign wr_ok     = wr_done & irs_wr_defined(idx);
	assign mack_rise = scl_rise & (state == ST_RDATA_ACK);
	assign rd_load   = scl_fall & (((state == ST_ADDR_ACK) & rw) |
	                               ((state == ST_RDATA_ACK) & ~mnack));
	assign rd_shift  = scl_fall & (state == ST_RDATA) & ~byte_full;
	assign rd_tgt    = last_wr ? irs_idx_dec(idx) : idx;

	// Framing; a start or stop overrides any state, the master owns the packet
	always_ff @(posedge clk_link_i or posedge rst_link) begin
		if (rst_link) begin
			state <= ST_IDLE;
			cnt   <= BIT_CNT_ZERO;
			sr    <= '0;
			rw    <= 1'b0;
			mnack <= 1'b0;
		end else if (start) begin
			state <= ST_ADDR;
			cnt   <= BIT_CNT_ZERO;
		end else if (stop) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (scl_rise && !byte_full) begin
						sr  <= {sr[DATA_W-2:0], sda_f};
						cnt <= cnt + BIT_CNT_ONE;
					end
					if (addr_done) begin
						rw    <= sr[0];
						state <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
					end
					if (reg_done) begin
						state <= ST_REG_ACK;
					end
					if (wr_done) begin
						state <= ST_WDATA_ACK;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						cnt   <= BIT_CNT_ZERO;
						state <= rw ? ST_RDATA : ST_REG;
					end
					if (rd_load) begin
						sr <= rbuf;
					end
				end
				ST_REG_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						cnt   <= BIT_CNT_ZERO;
						state <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise && !byte_full) begin
						cnt <= cnt + BIT_CNT_ONE;
					end
					if (rd_shift) begin
						sr <= {sr[DATA_W-2:0], 1'b0};
					end
					if (scl_fall && byte_full) begin
						state <= ST_RDATA_ACK;
					end
				end
				ST_RDATA_ACK: begin
					if (mack_rise) begin
						mnack <= sda_f;
					end
					if (scl_fall) begin
						cnt   <= BIT_CNT_ZERO;
						state <= mnack ? ST_IDLE : ST_RDATA;
					end
					if (rd_load) begin
						sr <= rbuf;
					end
				end
				ST_IDLE: begin
					cnt <= BIT_CNT_ZERO;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Only ever pulls low; the bus clock is never driven, no clock stretching
	always_ff @(posedge clk_link_i or posedge rst_link) begin
		if (rst_link) begin
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (start || stop) begin
			sda_oe_o <= 1'b0;
		end else if (addr_hit || reg_done || wr_ok) begin
			sda_oe_o <= 1'b1;
		end else if (rd_load) begin
			sda_oe_o <= ~rbuf[DATA_W-1];
		end else if (rd_shift) begin
			sda_oe_o <= ~sr[DATA_W-2];
		end else if (scl_fall) begin
			sda_oe_o <= 1'b0;
		end
	end

	// Index; it only ever points, register contents live outside
	always_ff @(posedge clk_link_i or posedge rst_link) begin
		if (rst_link) begin
			idx     <= IDX_RESET;
			last_wr <= 1'b0;
		end else if (reg_done) begin
			idx     <= sr[IDX_W-1:0];
			last_wr <= 1'b0;
		end else if (wr_ok) begin
			idx     <= irs_idx_inc(idx);
			last_wr <= 1'b1;
		end else if (rd_begin) begin
			idx     <= rd_tgt;
			last_wr <= 1'b0;
		end else if (mack_rise) begin
			idx <= irs_idx_inc(idx);
		end
	end

	// Requests toward the system domain; payload is held until the next toggle
	always_ff @(posedge clk_link_i or posedge rst_link) begin
		if (rst_link) begin
			req_tgl   <= 1'b0;
			req_we    <= 1'b0;
			req_addr  <= '0;
			req_wdata <= '0;
		end else if (wr_ok) begin
			req_tgl   <= ~req_tgl;
			req_we    <= 1'b1;
			req_addr  <= idx;
			req_wdata <= sr;
		end else if (rd_begin) begin
			req_tgl  <= ~req_tgl;
			req_we   <= 1'b0;
			req_addr <= rd_tgt;
		end else if (mack_rise && !sda_f) begin
			req_tgl  <= ~req_tgl;
			req_we   <= 1'b0;
			req_addr <= irs_idx_inc(idx);
		end
	end

	// Answers from the system domain
	always_ff @(posedge clk_link_i or posedge rst_link) begin
		if (rst_link) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
			ack_q    <= 1'b0;
		end else begin
			ack_meta <= ack_tgl;
			ack_sync <= ack_meta;
			ack_q    <= ack_sync;
		end
	end

	assign ack_pulse = ack_sync ^ ack_q;

	// Read data is stable on the system side before its toggle is seen here
	always_ff @(posedge clk_link_i or posedge rst_link) begin
		if (rst_link) begin
			rbuf <= '0;
		end else if (ack_pulse) begin
			rbuf <= rdata_x;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_q    <= 1'b0;
		end else begin
			req_meta <= req_tgl;
			req_sync <= req_meta;
			req_q    <= req_sync;
		end
	end

	assign req_pulse = req_sync ^ req_q;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			reg_wr_o    <= 1'b0;
			reg_rd_o    <= 1'b0;
			reg_addr_o  <= '0;
			reg_wdata_o <= '0;
		end else begin
			reg_wr_o <= req_pulse & req_we;
			reg_rd_o <= req_pulse & ~req_we;
			if (req_pulse) begin
				reg_addr_o <= req_addr;
			end
			if (req_pulse && req_we) begin
				reg_wdata_o <= req_wdata;
			end
		end
	end

	// Read data is sampled in the cycle the read strobe is high
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			ack_tgl <= 1'b0;
			rdata_x <= '0;
		end else begin
			if (reg_rd_o) begin
				rdata_x <= reg_rdata_i;
			end
			if (reg_rd_o || reg_wr_o) begin
				ack_tgl <= ~ack_tgl;
			end
		end
	end

endmodule

// *** shared/irs_pkg.sv ***
// Constants, state type and index helpers for the two-wire register slave
package irs_pkg;

	// Widths
	localparam int IDX_W     = 7;
	localparam int DATA_W    = 8;
	localparam int BIT_CNT_W = 4;

	// Framing
	localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO  = 4'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE   = 4'h1;

	// Upper five address bits, value arbitrary
	localparam logic [4:0] DEV_ADDR_FIXED = 5'h0b;

	// Register index range and reset value
	localparam logic [IDX_W-1:0] IDX_RESET = 7'h00;
	localparam logic [IDX_W-1:0] IDX_FIRST = 7'h00;
	localparam logic [IDX_W-1:0] IDX_LAST  = 7'h7f;
	localparam logic [IDX_W-1:0] IDX_STEP  = 7'h01;

	// Registers that accept a write
	localparam logic [IDX_W-1:0] REG_WR_FIRST = 7'h10;
	localparam logic [IDX_W-1:0] REG_WR_LAST  = 7'h15;

	// Glitch filter timing
	localparam int SPIKE_NS       = 50;
	localparam int LINK_PERIOD_NS = 80;
	localparam int FILT_LEN_DFLT  = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} irs_state_t;

	function automatic logic [IDX_W-1:0] irs_idx_inc(input logic [IDX_W-1:0] idx);
		if (idx == IDX_LAST) begin
			return IDX_FIRST;
		end
		return idx + IDX_STEP;
	endfunction

	function automatic logic [IDX_W-1:0] irs_idx_dec(input logic [IDX_W-1:0] idx);
		if (idx == IDX_FIRST) begin
			return IDX_LAST;
		end
		return idx - IDX_STEP;
	endfunction

	function automatic logic irs_wr_defined(input logic [IDX_W-1:0] idx);
		return (idx >= REG_WR_FIRST) && (idx <= REG_WR_LAST);
	endfunction

endpackage
